// file: bench/spi_slave_shifter_load_test.sv
// self-checking bench for the serial shifter-load core
`timescale 1ns/1ps
module spi_slave_shifter_load_test;
	logic sys_clk, rst, s_tx_valid, s_tx_ready, s_rx_valid, s_miso_o, s_miso_oe;
	logic [1:0] s_mode, m_mode;
	logic [7:0] s_tx_data, s_rx_data, m_tx_data, m_rx_data, a, b, c, d;
	logic s_sclk, s_mosi, s_ss_n, m_sel, m_tx_valid, m_tx_ready, m_stat_rd;
	logic m_vac, m_irq, m_rx_rd, m_rx_full, m_byp, m_sclk, m_mosi, m_ss_n;
	wire logic miso_w;
	int fails, n_checks, n_irq;
	assign miso_w = s_miso_oe ? s_miso_o : 1'bz;
	sssl_core #(.MST_HALF(4)) uut (.sys_clk(sys_clk), .rst(rst), .s_mode(s_mode),
		.s_tx_valid(s_tx_valid), .s_tx_data(s_tx_data), .s_tx_ready(s_tx_ready),
		.s_rx_valid(s_rx_valid), .s_rx_data(s_rx_data), .s_sclk(s_sclk), .s_mosi(s_mosi),
		.s_ss_n(s_ss_n), .s_miso_o(s_miso_o), .s_miso_oe(s_miso_oe), .m_mode(m_mode),
		.m_sel(m_sel), .m_tx_valid(m_tx_valid), .m_tx_data(m_tx_data), .m_tx_ready(m_tx_ready),
		.m_stat_rd(m_stat_rd), .m_tx_holding_vacant_event(m_vac), .m_vacant_irq(m_irq),
		.m_rx_rd(m_rx_rd), .m_rx_full(m_rx_full), .m_rx_data(m_rx_data),
		.m_miso_bypass(m_byp), .m_sclk(m_sclk), .m_mosi(m_mosi), .m_ss_n(m_ss_n),
		.m_miso_i(m_mosi));
	sssl_mst_model u_mst (.mode(s_mode), .miso(miso_w), .sclk(s_sclk), .mosi(s_mosi),
		.ss_n(s_ss_n));
	// count vacant pulses; each mode should see exactly one
	always @(posedge sys_clk) begin
		if (m_irq === 1'b1) n_irq <= n_irq + 1;
	end
	// core clock
	initial begin
		sys_clk = 1'b0;
		forever #2.5 sys_clk = ~sys_clk;
	end
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp) begin
			fails++;
			$display("ERROR %0t seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task give_verdict();
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask : give_verdict
	// bounded wait; sampled 1 ns after the edge so updates have landed
	task automatic wait_hi(ref logic s, input int lim);
		int k;
		k = 0;
		while (s !== 1'b1 && k < lim) begin
			@(posedge sys_clk);
			#1;
			k++;
		end
		if (s !== 1'b1) check(8'h00, 8'h01);
	endtask : wait_hi
	task put(input logic [7:0] v);
		@(posedge sys_clk);
		s_tx_valid <= 1'b1;
		s_tx_data <= v;
		@(posedge sys_clk);
		s_tx_valid <= 1'b0;
	endtask : put
	task mput(input logic [7:0] v);
		wait_hi(m_tx_ready, 50);
		@(posedge sys_clk);
		m_tx_valid <= 1'b1;
		m_tx_data <= v;
		@(posedge sys_clk);
		m_tx_valid <= 1'b0;
	endtask : mput
	// one-cycle strobe of a read: status or receive
	task rd(input bit st);
		@(posedge sys_clk);
		if (st) m_stat_rd <= 1'b1;
		else m_rx_rd <= 1'b1;
		@(posedge sys_clk);
		m_stat_rd <= 1'b0;
		m_rx_rd <= 1'b0;
	endtask : rd
	// one link byte: reply against queued value, received against sent
	task sx(input logic [7:0] dv, input logic [7:0] ev);
		logic [7:0] r;
		u_mst.xfer(dv, r);
		check(r, ev);
		wait_hi(s_rx_valid, 12);
		check(s_rx_data, dv);
	endtask : sx
	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		{rst, m_byp} = 2'b11;
		{s_tx_valid, m_sel, m_tx_valid, m_stat_rd, m_rx_rd} = 5'h00;
		{s_mode, m_mode, s_tx_data, m_tx_data} = 20'h00000;
		{fails, n_checks} = 64'h0;
		n_irq = 0;
		void'($urandom(32'h9EE53FC5));
		repeat (20) @(posedge sys_clk);
		rst <= 1'b0;
		for (int md = 0; md < 4; md++) begin
			{a, b, c, d} = $urandom;
			s_mode <= md[1:0];
			m_mode <= md[1:0];
			m_byp <= 1'($urandom);
			put(a);
			u_mst.sel();
			fork
				sx(d, a);
				begin
					wait_hi(s_tx_ready, 40);
					put(b);
				end
			join
			sx(8'h00, b);
			sx(8'hFF, sssl_pkg::FILL_BYTE);
			u_mst.desel();
			put(c);
			u_mst.noise();
			check({7'h00, s_tx_ready}, 8'h00);
			u_mst.sel();
			sx(d, c);
			u_mst.desel();
			// master side in loopback, two bytes before the status read
			m_sel <= 1'b1;
			for (int j = 0; j < 2; j++) begin
				mput(j ? c : d);
				wait_hi(m_rx_full, 200);
				check(m_rx_data, j ? c : d);
				check({7'h00, m_ss_n}, 8'h00);
				rd(1'b0);
			end
			check({7'h00, m_vac}, 8'h01);
			rd(1'b1);
			repeat (20) @(posedge sys_clk);
			#1;
			check({6'h00, m_vac, m_rx_full}, 8'h00);
			check(8'(n_irq), 8'(md + 1));
			m_sel <= 1'b0;
			$display("test mode %0d done", md);
		end
		give_verdict();
	end
	// watchdog, far beyond the expected run
	initial begin
		#50us;
		fails++;
		give_verdict();
	end
endmodule : spi_slave_shifter_load_test

// file: bench/sssl_core_chk.sv
// assertion checker for the serial shifter-load core
`timescale 1ns/1ps
module sssl_core_chk #(
	parameter int MST_HALF = 4
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [1:0] s_mode,
	input wire logic s_tx_valid,
	input wire logic s_tx_ready,
	input wire logic s_rx_valid,
	input wire logic s_ss_n,
	input wire logic s_miso_oe,
	input wire logic m_stat_rd,
	input wire logic m_tx_holding_vacant_event,
	input wire logic m_vacant_irq,
	input wire logic m_sclk
);
	// ----------------------------------------
	// helper counters
	// ----------------------------------------
	logic [3:0] hi_q;
	logic [3:0] sc_q;
	// select-high run length; the load crossing needs a few cycles to settle
	always_ff @(posedge sys_clk) begin
		if (rst || !s_ss_n) hi_q <= 4'h0;
		else if (hi_q != 4'hF) hi_q <= hi_q + 4'h1;
	end
	// cycles since the master clock last moved
	always_ff @(posedge sys_clk) begin
		if (rst || $changed(m_sclk)) sc_q <= 4'h0;
		else if (sc_q != 4'hF) sc_q <= sc_q + 4'h1;
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	// ----------------------------------------
	// properties
	// ----------------------------------------
	AST_OE_SEL: assert property (s_miso_oe == !s_ss_n)
		else $error("slave output enable not following select");
	AST_BUF_TAKEN: assert property (s_tx_valid && s_tx_ready |=> !s_tx_ready)
		else $error("slave buffer write not taken");
	AST_LOAD_AT_SEL: assert property ($fell(s_ss_n) && !s_mode[1] && !s_tx_ready |-> ##[1:6] s_tx_ready)
		else $error("no buffer load at select in phase 0");
	AST_HOLD_DESEL: assert property (hi_q >= 4'h8 && !s_tx_ready |=> !s_tx_ready)
		else $error("buffer consumed while deselected");
	AST_IRQ_EDGE: assert property (m_vacant_irq |-> m_tx_holding_vacant_event && !$past(m_tx_holding_vacant_event))
		else $error("vacant pulse while status already high");
	AST_STAT_STICK: assert property (m_tx_holding_vacant_event && !m_stat_rd |=> m_tx_holding_vacant_event)
		else $error("vacant status dropped without read");
	AST_STAT_IRQ: assert property ($rose(m_tx_holding_vacant_event) |-> m_vacant_irq)
		else $error("vacant status rose without pulse");
	AST_RXV_PULSE: assert property (s_rx_valid |=> !s_rx_valid)
		else $error("slave receive strobe longer than one cycle");
	AST_SCLK_HALF: assert property ($changed(m_sclk) |-> sc_q >= 4'(MST_HALF - 1))
		else $error("master clock half period too short");
endmodule : sssl_core_chk

bind sssl_core sssl_core_chk #(.MST_HALF(MST_HALF)) u_chk (.sys_clk(sys_clk), .rst(rst),
	.s_mode(s_mode), .s_tx_valid(s_tx_valid), .s_tx_ready(s_tx_ready),
	.s_rx_valid(s_rx_valid), .s_ss_n(s_ss_n), .s_miso_oe(s_miso_oe), .m_stat_rd(m_stat_rd),
	.m_tx_holding_vacant_event(m_tx_holding_vacant_event), .m_vacant_irq(m_vacant_irq),
	.m_sclk(m_sclk));

// file: bench/sssl_mst_model.sv
// behavioural link master that clocks the slave side of the core
`timescale 1ns/1ps
module sssl_mst_model (
	input wire logic [1:0] mode,
	input wire logic miso,
	output logic sclk,
	output logic mosi,
	output logic ss_n
);
	localparam realtime HALF = 6.0;
	// idle: clock still, select high
	initial begin
		sclk = 1'b0;
		mosi = 1'b0;
		ss_n = 1'b1;
	end
	// park clock at its polarity, then select
	task sel();
		sclk = mode[0];
		#3.7 ss_n = 1'b0;
		#HALF;
	endtask : sel
	// release; data line no longer shows the last bit
	task desel();
		#HALF ss_n = 1'b1;
		mosi = ~mosi;
	endtask : desel
	// whole byte out msb first, reply shifted in meanwhile
	task xfer(input logic [7:0] t, output logic [7:0] r);
		for (int i = 7; i >= 0; i--) begin
			if (!mode[1]) mosi = t[i];
			#HALF sclk = ~sclk;
			if (mode[1]) mosi = t[i];
			else r[i] = miso;
			#HALF sclk = ~sclk;
			if (mode[1]) r[i] = miso;
		end
	endtask : xfer
	// link activity while deselected, which the slave must ignore
	task noise();
		repeat (16) begin
			#HALF sclk = ~sclk;
			mosi = ~mosi;
		end
	endtask : noise
endmodule : sssl_mst_model

// file: verilog/sssl_core.sv
// serial slave with transmit buffer to shifter load control, plus a small master
`timescale 1ns/1ps
module sssl_core #(
	parameter int MST_HALF = sssl_pkg::MST_HALF_CYC
) (
	input wire logic sys_clk,
	input wire logic rst,
	// slave user side
	input wire logic [1:0] s_mode,
	input wire logic s_tx_valid,
	input wire logic [7:0] s_tx_data,
	output logic s_tx_ready,
	output logic s_rx_valid,
	output logic [7:0] s_rx_data,
	// slave link side
	input wire logic s_sclk,
	input wire logic s_mosi,
	input wire logic s_ss_n,
	output logic s_miso_o,
	output logic s_miso_oe,
	// master user side
	input wire logic [1:0] m_mode,
	input wire logic m_sel,
	input wire logic m_tx_valid,
	input wire logic [7:0] m_tx_data,
	output logic m_tx_ready,
	input wire logic m_stat_rd,
	output logic m_tx_holding_vacant_event,
	output logic m_vacant_irq,
	input wire logic m_rx_rd,
	output logic m_rx_full,
	output logic [7:0] m_rx_data,
	input wire logic m_miso_bypass,
	// master link side
	output logic m_sclk,
	output logic m_mosi,
	output logic m_ss_n,
	input wire logic m_miso_i
);

	// ----------------------------------------------------------------
	// slave: system-side transmit buffer
	// ----------------------------------------------------------------
	logic s_full_q;
	logic [7:0] s_hold_q;
	logic [2:0] s_sy1_q;
	logic [2:0] s_sy2_q;
	logic [2:0] s_sy3_q;
	logic [2:0] s_ev;
	logic s_consumed;
	logic [7:0] s_rx_q;
	logic s_rx_valid_q;

	// link-domain state, clocked by the serial clock or by select
	logic ls_cpha;
	logic ls_clk;
	logic [7:0] ls_next;
	logic [7:0] ls_snap_q;
	logic ls_snap_tog_q;
	logic ls_first_q;
	logic [2:0] ls_lcnt_q;
	logic [7:0] ls_sh_q;
	logic ls_load_tog_q;
	logic [2:0] ls_scnt_q;
	logic [7:0] ls_rsh_q;
	logic [7:0] ls_rx_word_q;
	logic ls_rx_tog_q;

	assign s_tx_ready = ~s_full_q;
	assign s_rx_data = s_rx_q;
	assign s_rx_valid = s_rx_valid_q;
	assign s_ev = s_sy2_q ^ s_sy3_q;
	assign s_consumed = s_ev[0] | s_ev[1];

	// buffer accept and vacate; write and consume never overlap
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_full_q <= 1'b0;
			s_hold_q <= sssl_pkg::RESET_BYTE;
		end else if (s_full_q && s_consumed) begin
			s_full_q <= 1'b0;
		end else if (s_tx_valid && !s_full_q) begin
			s_full_q <= 1'b1;
			s_hold_q <= s_tx_data;
		end
	end

	// toggle crossings from the link: snapshot, load, receive
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_sy1_q <= 3'h0;
			s_sy2_q <= 3'h0;
			s_sy3_q <= 3'h0;
		end else begin
			s_sy1_q <= {ls_rx_tog_q, ls_load_tog_q, ls_snap_tog_q};
			s_sy2_q <= s_sy1_q;
			s_sy3_q <= s_sy2_q;
		end
	end

	// received word is stable long before its toggle is seen here
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			s_rx_q <= sssl_pkg::RESET_BYTE;
			s_rx_valid_q <= 1'b0;
		end else begin
			s_rx_valid_q <= s_ev[2];
			if (s_ev[2]) begin
				s_rx_q <= ls_rx_word_q;
			end
		end
	end

	// ----------------------------------------------------------------
	// slave: link domain
	// ----------------------------------------------------------------
	// mode must only change while select is high; it steers the clock
	assign ls_cpha = s_mode[sssl_pkg::MODE_CPHA];
	// rising edge of ls_clk is the sampling edge in every mode
	assign ls_clk = s_sclk ^ s_mode[sssl_pkg::MODE_CPOL] ^ ls_cpha;
	// buffer word is held stable while full, so it is a safe handshake
	assign ls_next = s_full_q ? s_hold_q : sssl_pkg::FILL_BYTE;
	assign s_miso_o = (!ls_cpha && ls_first_q) ? ls_snap_q[7] : ls_sh_q[7];
	assign s_miso_oe = ~s_ss_n;

	// select assertion captures the buffer for modes 0 and 1
	always_ff @(negedge s_ss_n or posedge rst) begin
		if (rst) begin
			ls_snap_q <= sssl_pkg::RESET_BYTE;
			ls_snap_tog_q <= 1'b0;
		end else begin
			ls_snap_q <= ls_next;
			if (!ls_cpha && s_full_q) begin
				ls_snap_tog_q <= ~ls_snap_tog_q;
			end
		end
	end

	// launch edge: shift out, and load between bytes
	always_ff @(negedge ls_clk or posedge s_ss_n) begin
		if (s_ss_n) begin
			ls_first_q <= 1'b1;
			ls_lcnt_q <= 3'h0;
			ls_sh_q <= sssl_pkg::RESET_BYTE;
		end else begin
			ls_first_q <= 1'b0;
			ls_lcnt_q <= ls_lcnt_q + 3'h1;
			if (ls_cpha) begin
				if (ls_lcnt_q == 3'h0) begin
					ls_sh_q <= ls_next;
				end else begin
					ls_sh_q <= {ls_sh_q[6:0], 1'b0};
				end
			end else if (ls_first_q) begin
				ls_sh_q <= {ls_snap_q[6:0], 1'b0};
			end else if (ls_lcnt_q == sssl_pkg::LAST_BIT) begin
				ls_sh_q <= ls_next;
			end else begin
				ls_sh_q <= {ls_sh_q[6:0], 1'b0};
			end
		end
	end

	// report loads; released select blocks the load edge entirely
	always_ff @(negedge ls_clk or posedge rst) begin
		if (rst) begin
			ls_load_tog_q <= 1'b0;
		end else if (!s_ss_n && s_full_q) begin
			if (ls_cpha ? (ls_lcnt_q == 3'h0) : (ls_lcnt_q == sssl_pkg::LAST_BIT)) begin
				ls_load_tog_q <= ~ls_load_tog_q;
			end
		end
	end

	// sampling edge: shift in from the master
	always_ff @(posedge ls_clk or posedge s_ss_n) begin
		if (s_ss_n) begin
			ls_scnt_q <= 3'h0;
			ls_rsh_q <= sssl_pkg::RESET_BYTE;
		end else begin
			ls_scnt_q <= ls_scnt_q + 3'h1;
			ls_rsh_q <= {ls_rsh_q[6:0], s_mosi};
		end
	end

	// completed byte handed over with a toggle
	always_ff @(posedge ls_clk or posedge rst) begin
		if (rst) begin
			ls_rx_word_q <= sssl_pkg::RESET_BYTE;
			ls_rx_tog_q <= 1'b0;
		end else if (!s_ss_n && ls_scnt_q == sssl_pkg::LAST_BIT) begin
			ls_rx_word_q <= {ls_rsh_q[6:0], s_mosi};
			ls_rx_tog_q <= ~ls_rx_tog_q;
		end
	end

	// ----------------------------------------------------------------
	// master: input synchroniser, buffer, status
	// ----------------------------------------------------------------
	sssl_pkg::sssl_mst_state_t m_state_q;
	logic m_miso_s;
	logic m_full_q;
	logic [7:0] m_hold_q;
	logic m_start;
	logic m_vac_q;
	logic m_irq_q;
	logic m_cpol;
	logic m_cpha;
	logic [15:0] m_div_q;
	logic [3:0] m_edge_q;
	logic [7:0] m_sh_q;
	logic m_bit_q;
	logic m_sclk_q;
	logic m_mosi_q;
	logic m_ss_n_q;
	logic m_fin;
	logic [7:0] m_fin_word;
	logic m_rx_full_q;
	logic [7:0] m_rx_q;

	// default synchronised; bypass recommended at fast serial rates
	sssl_in_sync #(
		.W(1)
	) u_miso_sync (
		.clk(sys_clk),
		.rst(rst),
		.async_in(m_miso_i),
		.bypass(m_miso_bypass),
		.sync_out(m_miso_s)
	);

	assign m_cpol = m_mode[sssl_pkg::MODE_CPOL];
	assign m_cpha = m_mode[sssl_pkg::MODE_CPHA];
	// a byte only moves when software queued one and selected the slave
	assign m_start = (m_state_q == sssl_pkg::M_IDLE) && m_full_q && m_sel;
	assign m_tx_ready = ~m_full_q;
	assign m_tx_holding_vacant_event = m_vac_q;
	assign m_vacant_irq = m_irq_q;
	assign m_sclk = m_sclk_q;
	assign m_mosi = m_mosi_q;
	assign m_ss_n = m_ss_n_q;
	assign m_rx_full = m_rx_full_q;
	assign m_rx_data = m_rx_q;

	// transmit holding register
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			m_full_q <= 1'b0;
			m_hold_q <= sssl_pkg::RESET_BYTE;
		end else if (m_start) begin
			m_full_q <= 1'b0;
		end else if (m_tx_valid && !m_full_q) begin
			m_full_q <= 1'b1;
			m_hold_q <= m_tx_data;
		end
	end

	// vacant status is sticky until read; set beats the read
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			m_vac_q <= 1'b0;
			m_irq_q <= 1'b0;
		end else begin
			m_irq_q <= m_start && !m_vac_q;
			if (m_start) begin
				m_vac_q <= 1'b1;
			end else if (m_stat_rd) begin
				m_vac_q <= 1'b0;
			end
		end
	end

	// ----------------------------------------------------------------
	// master: sequencer and shifter
	// ----------------------------------------------------------------
	assign m_fin = (m_state_q == sssl_pkg::M_SHIFT) && (m_div_q == 16'(MST_HALF - 1))
		&& (m_edge_q == sssl_pkg::LAST_EDGE);
	assign m_fin_word = {m_sh_q[6:0], m_cpha ? m_miso_s : m_bit_q};

	// select follows software directly
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			m_ss_n_q <= 1'b1;
		end else begin
			m_ss_n_q <= ~m_sel;
		end
	end

	// edges alternate leading/trailing; even edge index is leading
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			m_state_q <= sssl_pkg::M_IDLE;
			m_div_q <= 16'h0000;
			m_edge_q <= 4'h0;
			m_sh_q <= sssl_pkg::RESET_BYTE;
			m_bit_q <= 1'b0;
			m_sclk_q <= 1'b0;
			m_mosi_q <= 1'b0;
		end else begin
			case (m_state_q)
				sssl_pkg::M_IDLE: begin
					m_sclk_q <= m_cpol;
					m_div_q <= 16'h0000;
					m_edge_q <= 4'h0;
					if (m_start) begin
						m_sh_q <= m_hold_q;
						m_mosi_q <= m_hold_q[7];
						m_state_q <= sssl_pkg::M_SHIFT;
					end
				end
				sssl_pkg::M_SHIFT: begin
					if (m_div_q == 16'(MST_HALF - 1)) begin
						m_div_q <= 16'h0000;
						m_sclk_q <= ~m_sclk_q;
						m_edge_q <= m_edge_q + 4'h1;
						if (!m_edge_q[0]) begin
							m_bit_q <= m_miso_s;
							if (m_cpha) begin
								m_mosi_q <= m_sh_q[7];
							end
						end else begin
							m_sh_q <= m_fin_word;
							if (!m_cpha) begin
								m_mosi_q <= m_sh_q[6];
							end
							if (m_fin) begin
								m_state_q <= sssl_pkg::M_DONE;
							end
						end
					end else begin
						m_div_q <= m_div_q + 16'h0001;
					end
				end
				sssl_pkg::M_DONE: begin
					m_state_q <= sssl_pkg::M_IDLE;
				end
				default: begin
					m_state_q <= sssl_pkg::M_IDLE;
				end
			endcase
		end
	end

	// receive register; a read only drops the flag, nothing else
	always_ff @(posedge sys_clk) begin
		if (rst) begin
			m_rx_full_q <= 1'b0;
			m_rx_q <= sssl_pkg::RESET_BYTE;
		end else if (m_fin) begin
			m_rx_full_q <= 1'b1;
			m_rx_q <= m_fin_word;
		end else if (m_rx_rd) begin
			m_rx_full_q <= 1'b0;
		end
	end

endmodule : sssl_core

// file: verilog/sssl_in_sync.sv
// per-input two-stage synchroniser with a bypass select for each input
`timescale 1ns/1ps
module sssl_in_sync #(
	parameter int W = 1
) (
	input wire logic clk,
	input wire logic rst,
	input wire logic [W-1:0] async_in,
	input wire logic [W-1:0] bypass,
	output logic [W-1:0] sync_out
);

	// ----------------------------------------------------------------
	// one synchroniser per input bit
	// ----------------------------------------------------------------
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			logic meta_q;
			logic stab_q;
			// first stage feeds only the second
			always_ff @(posedge clk) begin
				if (rst) begin
					meta_q <= 1'b0;
					stab_q <= 1'b0;
				end else begin
					meta_q <= async_in[i];
					stab_q <= meta_q;
				end
			end
			// bypass trades metastability margin for two cycles less delay
			assign sync_out[i] = bypass[i] ? async_in[i] : stab_q;
		end
	endgenerate

endmodule : sssl_in_sync

// file: verilog/sssl_pkg.sv
// shared constants and types for the serial shifter-load block
package sssl_pkg;

	// ----------------------------------------------------------------
	// data and mode layout
	// ----------------------------------------------------------------
	localparam int BYTE_W = 8;
	localparam int CNT_W = 3;
	localparam int EDGE_W = 4;
	localparam int MODE_W = 2;
	localparam int MODE_CPOL = 0;
	localparam int MODE_CPHA = 1;
	localparam logic [2:0] LAST_BIT = 3'h7;
	localparam logic [3:0] LAST_EDGE = 4'hF;

	// ----------------------------------------------------------------
	// reset and fill values
	// ----------------------------------------------------------------
	localparam logic [7:0] FILL_BYTE = 8'hFF;
	localparam logic [7:0] RESET_BYTE = 8'h00;

	// ----------------------------------------------------------------
	// timing
	// ----------------------------------------------------------------
	localparam int SYS_CLK_PS = 5000;
	localparam int MST_HALF_NS = 20;
	localparam int MST_HALF_RAW = (MST_HALF_NS * 1000 + SYS_CLK_PS - 1) / SYS_CLK_PS;
	localparam int MST_HALF_CYC = (MST_HALF_RAW < 1) ? 1 : MST_HALF_RAW;
	// above this serial rate the input synchroniser should be bypassed
	localparam int SYNC_BYPASS_ABOVE_KHZ = 1000;

	// ----------------------------------------------------------------
	// master sequencer states
	// ----------------------------------------------------------------
	typedef enum logic [1:0] {
		M_IDLE,
		M_SHIFT,
		M_DONE
	} sssl_mst_state_t;

endpackage : sssl_pkg
